// ==== common/irq_bank_pkg.sv ====
// constants for the interrupt flag and enable bank
package irq_bank_pkg;
	localparam int          NUM_CTRL      = 9;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFS_PRIM_B    = 8'h00;
	localparam logic [7:0]  OFS_PRIM_C    = 8'h04;
	localparam logic [7:0]  OFS_PRIM_D    = 8'h08;
	localparam logic [7:0]  OFS_GRP_ZERO  = 8'h0C;
	localparam logic [7:0]  OFS_GRP_ONE   = 8'h10;
	localparam logic [7:0]  OFS_GRP_TWO   = 8'h14;
	localparam logic [7:0]  OFS_GRP_THREE = 8'h18;
	localparam logic [7:0]  OFS_GRP_FOUR  = 8'h1C;
	localparam logic [7:0]  OFS_GRP_FIVE  = 8'h20;
	localparam logic [7:0]  OFS_GLOBAL    = 8'h24;
	localparam logic [7:0]  OFS_EVT_STAT  = 8'h28;
	localparam logic [7:0]  OFS_EVT_CLR   = 8'h2C;
	localparam logic [7:0]  OFS_EVT_EN    = 8'h30;
	localparam logic [3:0]  IDX_GLOBAL    = 4'h9;
	localparam logic [3:0]  IDX_EVT_STAT  = 4'hA;
	localparam logic [3:0]  IDX_EVT_CLR   = 4'hB;
	localparam logic [3:0]  IDX_EVT_EN    = 4'hC;
	localparam logic [3:0]  IDX_NONE      = 4'hF;
	localparam int          FLAG_LSB      = 4;
	localparam int          ENA_LSB       = 0;
	localparam int          GLOBAL_EN_BIT = 0;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  GLOBAL_RESET  = 8'h00;
	localparam logic [3:0]  EVT_RESET     = 4'h0;
	localparam logic [7:0]  MASK_FULL     = 8'hFF;
	localparam logic [7:0]  MASK_HALF     = 8'h33;
	localparam int          EVT_PIN2      = 0;
	localparam int          EVT_PIN3      = 1;
	localparam int          EVT_WAKE      = 2;
	localparam int          EVT_SERVICE   = 3;
	localparam int          IDX_GRP_ZERO  = 3;
endpackage

// ==== rtl/interrupt_flag_enable_bank.sv ====
// interrupt request flag and enable bank with apb register access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module interrupt_flag_enable_bank
	import irq_bank_pkg::*;
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [irq_bank_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// request sources, one-cycle pulses on clk
	input  wire logic                       converterDone,
	input  wire logic [3:0]                 group0Event,
	input  wire logic [3:0]                 group1Event,
	input  wire logic [1:0]                 group2Event,
	input  wire logic [3:0]                 group3Event,
	input  wire logic [3:0]                 group4Event,
	input  wire logic [1:0]                 group5Event,
	// pending levels of groups held outside
	input  wire logic                       group7Pending,
	input  wire logic                       group8Pending,
	input  wire logic                       group9Pending,
	// asynchronous external pins
	input  wire logic                       extPin2,
	input  wire logic                       extPin3,
	// core side
	input  wire logic                       serviceEnter,
	input  wire logic                       lowPowerMode,
	output logic                            coreIrq,
	output logic                            wakeUp,
	output logic                            irqOut
);
	import irq_bank_pkg::*;

	// address decode shared by read and write
	function automatic logic [3:0] decodeAddr(input logic [ADDR_W-1:0] a);
		logic [3:0] r;
		r = IDX_NONE;
		case (a)
			OFS_PRIM_B:    r = 4'h0;
			OFS_PRIM_C:    r = 4'h1;
			OFS_PRIM_D:    r = 4'h2;
			OFS_GRP_ZERO:  r = 4'h3;
			OFS_GRP_ONE:   r = 4'h4;
			OFS_GRP_TWO:   r = 4'h5;
			OFS_GRP_THREE: r = 4'h6;
			OFS_GRP_FOUR:  r = 4'h7;
			OFS_GRP_FIVE:  r = 4'h8;
			OFS_GLOBAL:    r = IDX_GLOBAL;
			OFS_EVT_STAT:  r = IDX_EVT_STAT;
			OFS_EVT_CLR:   r = IDX_EVT_CLR;
			OFS_EVT_EN:    r = IDX_EVT_EN;
			default:       r = IDX_NONE;
		endcase
		return r;
	endfunction

	// implemented bits per control register
	function automatic logic [7:0] ctrlMask(input int i);
		logic [7:0] m;
		m = MASK_FULL;
		if (i == 5 || i == 8) begin
			m = MASK_HALF;
		end
		return m;
	endfunction

	logic [7:0]  ctrl_q [NUM_CTRL];
	logic [7:0]  ctrl_d [NUM_CTRL];
	logic [3:0]  setEvt [NUM_CTRL];
	logic [5:0]  grpPend;
	logic [NUM_CTRL-1:0] newFlag;
	logic        global_q;
	logic [3:0]  evtStat_q;
	logic [3:0]  evtEn_q;
	logic [3:0]  evtSet;
	logic        pin2Edge;
	logic        pin3Edge;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_d;
	logic [3:0]  accIdx;
	logic        wrStrobe;
	logic        rdCapture;
	logic        wrGlobal;
	logic        wrEvtClr;
	logic        wrEvtEn;
	logic [2:0]  primPend;
	logic        pendAny;
	logic        coreIrq_q;
	logic        wakeUp_q;
	logic        irqOut_q;

	assign accIdx    = decodeAddr(paddr);
	assign wrStrobe  = psel & penable & pready_q & pwrite;
	assign rdCapture = psel & penable & ~pready_q;

	// write selects for the writable non-control registers
	assign wrGlobal  = wrStrobe & (accIdx == IDX_GLOBAL);
	assign wrEvtClr  = wrStrobe & (accIdx == IDX_EVT_CLR);
	assign wrEvtEn   = wrStrobe & (accIdx == IDX_EVT_EN);

	// pin synchronisers: two flops, third flop for rising edge detect
	logic [1:0] pinRaw;
	logic [1:0] pinEdge;
	logic [2:0] pinSync_q [2];
	assign pinRaw = {extPin3, extPin2};
	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : gen_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					pinSync_q[s] <= 3'h0;
				end else begin
					pinSync_q[s] <= {pinSync_q[s][1:0], pinRaw[s]};
				end
			end
			assign pinEdge[s] = pinSync_q[s][1] & ~pinSync_q[s][2];
		end
	endgenerate
	assign pin2Edge = pinEdge[0];
	assign pin3Edge = pinEdge[1];

	// group pending: any source flagged and enabled
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : gen_pend
			assign grpPend[g] = |(ctrl_q[IDX_GRP_ZERO+g][7:FLAG_LSB]
				& ctrl_q[IDX_GRP_ZERO+g][FLAG_LSB-1:ENA_LSB]);
		end
	endgenerate

	// request sources in flag bit order 7..4
	always_comb begin
		setEvt[0] = {converterDone, grpPend[1], grpPend[0], group7Pending};
		setEvt[1] = {grpPend[3], group9Pending, group8Pending, grpPend[2]};
		setEvt[2] = {grpPend[5], grpPend[4], pin3Edge, pin2Edge};
		setEvt[3] = group0Event;
		setEvt[4] = group1Event;
		setEvt[5] = {2'h0, group2Event};
		setEvt[6] = group3Event;
		setEvt[7] = group4Event;
		setEvt[8] = {2'h0, group5Event};
	end

	// control registers: source set wins over software write
	genvar i;
	generate
		for (i = 0; i < NUM_CTRL; i++) begin : gen_ctrl
			logic [7:0] implMask;
			logic [3:0] flagMask;
			logic       wrHit;
			assign implMask = ctrlMask(i);
			assign flagMask = implMask[7:FLAG_LSB];
			assign wrHit    = wrStrobe & (accIdx == 4'(i));
			always_comb begin
				ctrl_d[i] = ctrl_q[i];
				if (wrHit) begin
					ctrl_d[i] = pwdata[7:0] & implMask;
				end
				ctrl_d[i][7:FLAG_LSB] = ctrl_d[i][7:FLAG_LSB] | (setEvt[i] & flagMask);
			end
			assign newFlag[i] = |(setEvt[i] & flagMask & ~ctrl_q[i][7:FLAG_LSB]);
			always_ff @(posedge clk) begin
				if (rst) begin
					ctrl_q[i] <= CTRL_RESET;
				end else begin
					ctrl_q[i] <= ctrl_d[i];
				end
			end
		end
	endgenerate

	// global enable, cleared on service entry
	always_ff @(posedge clk) begin
		if (rst) begin
			global_q <= GLOBAL_RESET[GLOBAL_EN_BIT];
		end else if (serviceEnter) begin
			global_q <= 1'b0;
		end else if (wrGlobal) begin
			global_q <= pwdata[GLOBAL_EN_BIT];
		end
	end

	// primary enabled requests toward the core
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : gen_prim
			assign primPend[p] = |(ctrl_q[p][7:FLAG_LSB] & ctrl_q[p][FLAG_LSB-1:ENA_LSB]);
		end
	endgenerate
	assign pendAny = |primPend;

	// request toward the core, one cycle after the flags

	always_ff @(posedge clk) begin
		if (rst) begin
			coreIrq_q <= 1'b0;
		end else begin
			coreIrq_q <= pendAny & global_q & ~serviceEnter;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wakeUp_q <= 1'b0;
		end else begin
			wakeUp_q <= lowPowerMode & (|newFlag);
		end
	end

	// sticky event status, write one to clear, set wins
	assign evtSet = {serviceEnter, wakeUp_q, pin3Edge, pin2Edge};
	always_ff @(posedge clk) begin
		if (rst) begin
			evtStat_q <= EVT_RESET;
		end else if (wrEvtClr) begin
			evtStat_q <= (evtStat_q & ~pwdata[3:0]) | evtSet;
		end else begin
			evtStat_q <= evtStat_q | evtSet;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evtEn_q <= EVT_RESET;
		end else if (wrEvtEn) begin
			evtEn_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqOut_q <= 1'b0;
		end else begin
			irqOut_q <= |(evtStat_q & evtEn_q);
		end
	end

	// read mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (accIdx)
			IDX_GLOBAL: begin
				rdata_d[GLOBAL_EN_BIT] = global_q;
			end
			IDX_EVT_STAT: begin
				rdata_d[3:0] = evtStat_q;
			end
			IDX_EVT_EN: begin
				rdata_d[3:0] = evtEn_q;
			end
			IDX_EVT_CLR, IDX_NONE: begin
				rdata_d = 32'h0000_0000;
			end
			default: begin
				if (accIdx < 4'(NUM_CTRL)) begin
					rdata_d[7:0] = ctrl_q[accIdx] & ctrlMask(int'(accIdx));
				end
			end
		endcase
	end

	// apb: one wait state, answer in second access cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= rdCapture;
		end
	end

	// unmapped address answers with an error
	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= rdCapture & (accIdx == IDX_NONE);
		end
	end

	// read data taken in first access cycle, writes read back zero
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (rdCapture) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign coreIrq = coreIrq_q;
	assign wakeUp  = wakeUp_q;
	assign irqOut  = irqOut_q;
endmodule

// ==== tb/interrupt_flag_enable_bank_tb.sv ====
// register level bench for the interrupt bank
`timescale 1ns/1ps
module interrupt_flag_enable_bank_tb;
	import irq_bank_pkg::*;
	logic clk, rst, psel, penable, pwrite, converterDone, serviceEnter, lowPowerMode;
	logic group7Pending, group8Pending, group9Pending, pready, pslverr, coreIrq, wakeUp, irqOut;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  group0Event, group1Event, group3Event, group4Event;
	logic [1:0]  group2Event, group5Event, kick;
	wire         extPin2, extPin3;
	int          fail_count, checked, wakes;
	logic [7:0]  ev [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h80, 8'h10};
	interrupt_flag_enable_bank dut (.*);
	pin_src_model psrc (.clk(clk), .kick(kick), .pins({extPin3, extPin2}));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) if (wakeUp === 1'b1) wakes++;
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(0, a, 0, q, e);
		chk(q, x);
	endtask
	task automatic complete_run();
		$display("mismatches %0d of %0d checks", fail_count, checked);
		if (fail_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		complete_run();
	end
	initial begin
		logic [31:0] q;
		logic e;
		rst = 1;
		{psel, penable, pwrite, paddr, pwdata, converterDone, serviceEnter, lowPowerMode, kick} = '0;
		{group7Pending, group8Pending, group9Pending} = '0;
		{group0Event, group1Event, group2Event, group3Event, group4Event, group5Event} = '0;
		repeat (2) @(posedge clk);
		rst <= 0;
		for (int i = 0; i < 9; i++) rd(8'(4 * i), 0);
		for (int i = 0; i < 9; i++) begin
			wr(8'(4 * i), 32'hFF);
			rd(8'(4 * i), (i == 5 || i == 8) ? 32'h33 : 32'hFF);
			wr(8'(4 * i), 0);
		end
		for (int i = 0; i < 3; i++) wr(8'(4 * i), 0);
		@(posedge clk);
		{converterDone, group0Event, group1Event, group2Event} <= {1'b1, 4'h8, 4'h4, 2'h2};
		{group3Event, group4Event, group5Event} <= {4'h1, 4'h8, 2'h1};
		@(posedge clk);
		{converterDone, group0Event, group1Event, group2Event, group3Event, group4Event, group5Event} <= '0;
		rd(OFS_PRIM_B, 32'h80);
		for (int i = 0; i < 6; i++) rd(8'(12 + 4 * i), ev[i]);
		wr(OFS_GRP_ZERO, 32'h88);
		rd(OFS_PRIM_B, 32'hA0);
		wr(OFS_PRIM_B, 32'hA2);
		repeat (3) @(posedge clk);
		chk(coreIrq, 0);
		wr(OFS_GLOBAL, 1);
		repeat (3) @(posedge clk);
		chk(coreIrq, 1);
		serviceEnter <= 1;
		group0Event <= 4'h4;
		@(posedge clk);
		{serviceEnter, group0Event} <= '0;
		repeat (2) @(posedge clk);
		chk(coreIrq, 0);
		rd(OFS_GLOBAL, 0);
		rd(OFS_GRP_ZERO, 32'hC8);
		rd(OFS_EVT_STAT, 8);
		chk(irqOut, 0);
		wr(OFS_EVT_EN, 8);
		repeat (2) @(posedge clk);
		chk(irqOut, 1);
		wr(OFS_EVT_CLR, 8);
		rd(OFS_EVT_STAT, 0);
		rd(OFS_EVT_CLR, 0);
		chk(irqOut, 0);
		kick <= 2'b11;
		{group7Pending, group8Pending, group9Pending} <= 3'h7;
		@(posedge clk);
		kick <= 0;
		{group7Pending, group8Pending, group9Pending} <= 3'h0;
		repeat (8) @(posedge clk);
		rd(OFS_PRIM_D, 32'h30);
		rd(OFS_EVT_STAT, 32'h3);
		rd(OFS_PRIM_C, 32'h60);
		rd(OFS_PRIM_B, 32'hB2);
		lowPowerMode <= 1;
		for (int i = 0; i < 2; i++) begin
			group3Event <= 4'h4;
			@(posedge clk);
			group3Event <= 0;
			repeat (4) @(posedge clk);
			chk(wakes, 1);
		end
		rd(OFS_EVT_STAT, 32'h7);
		apb(0, 8'h40, 0, q, e);
		chk(q, 0);
		chk(e, 1);
		complete_run();
	end
endmodule

// ==== tb/irq_bank_props.sv ====
// apb timing and interrupt output checks
`timescale 1ns/1ps
module irq_bank_props
	import irq_bank_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// core side
	input wire logic              serviceEnter,
	input wire logic              lowPowerMode,
	input wire logic              coreIrq,
	input wire logic              wakeUp,
	input wire logic              irqOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire setup = psel && !penable;
	wire rdSetup = setup && !pwrite;
	one_wait_a: assert property (setup |-> ##2 pready) else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	err_qual_a: assert property (pslverr |-> pready) else $error("error without ready");
	bad_addr_a: assert property (rdSetup && paddr > OFS_EVT_EN |-> ##2 pslverr && prdata == 0) else $error("bad addr");
	map_ok_a: assert property (setup && paddr <= OFS_EVT_EN && paddr[1:0] == 0 |-> ##2 !pslverr) else $error("error");
	half_reg_a: assert property (rdSetup && (paddr == OFS_GRP_TWO || paddr == OFS_GRP_FIVE)
		|-> ##2 (prdata & ~32'h33) == 0) else $error("unused bits");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 0) else $error("upper bits");
	service_block_a: assert property (serviceEnter |=> !coreIrq) else $error("irq in service");
	wake_lp_a: assert property (wakeUp |-> $past(lowPowerMode)) else $error("wake awake");
	wake_pulse_a: assert property (wakeUp |=> !wakeUp) else $error("wake held");
	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !coreIrq && !irqOut && !wakeUp && !pready)
		else $error("busy in reset");
	cover property ($rose(coreIrq));
	cover property (pslverr);
	cover property (wakeUp);
endmodule
bind interrupt_flag_enable_bank irq_bank_props chk (.*);

// ==== tb/pin_src_model.sv ====
// external pin source, holds a pin high six cycles per kick
`timescale 1ns/1ps
module pin_src_model (
	// clock
	input  wire logic       clk,
	// requests
	input  wire logic [1:0] kick,
	// pins
	output logic      [1:0] pins
);
	logic [2:0] cnt [2] = '{3'h0, 3'h0};
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (kick[i]) cnt[i] <= 3'h6;
			else if (cnt[i] != 0) cnt[i] <= cnt[i] - 3'h1;
		end
	end
	assign pins = {cnt[1] != 0, cnt[0] != 0};
endmodule
